/* File: include/arpt_pkg.sv */
// Constants shared by the auto-reload PWM timer: register map and fields
package arpt_pkg;

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [7:0] IDX_DUTY3 = 8'h73; // Duty cycle, channel 3
    localparam logic [7:0] IDX_DUTY2 = 8'h74; // Duty cycle, channel 2
    localparam logic [7:0] IDX_DUTY1 = 8'h75; // Duty cycle, channel 1
    localparam logic [7:0] IDX_DUTY0 = 8'h76; // Duty cycle, channel 0
    localparam logic [7:0] IDX_PWM_OUTPUT_CONTROL = 8'h77; // Output enable and polarity
    localparam logic [7:0] IDX_CSR = 8'h78; // Timer control and status
    localparam logic [7:0] IDX_CAR = 8'h79; // Live counter access
    localparam logic [7:0] IDX_ARR = 8'h7a; // Auto-reload value
    localparam logic [7:0] IDX_INT_STAT = 8'h80; // Sticky event status, RO
    localparam logic [7:0] IDX_INT_CLR = 8'h81; // Write one to clear, WO
    localparam logic [7:0] IDX_INT_EN = 8'h82; // Event enable

    // ==========================================================
    // Control/status field positions
    localparam int CSR_EXT_SEL = 7; // Prescaler input select
    localparam int CSR_PS_HI = 6; // Prescale select, top bit
    localparam int CSR_PS_LO = 4; // Prescale select, low bit
    localparam int CSR_CNT_EN = 3; // Count enable
    localparam int CSR_FRELOAD = 2; // Force reload, write-only
    localparam int CSR_OIE = 1; // Overflow interrupt enable
    localparam int CSR_OVF = 0; // Overflow flag
    localparam int PWM_OUTPUT_CONTROL_OE_LO = 4; // Output enables in [7:4]
    localparam int INT_OVF_BIT = 0; // Overflow event in status word

    // ==========================================================
    // Reset values and counter limits
    localparam logic [7:0] CSR_RST = 8'h00;
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [7:0] ARR_RST = 8'h00;
    localparam logic [7:0] PWM_OUTPUT_CONTROL_RST = 8'h00;
    localparam logic [7:0] DUTY_RST = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam int PRESC_W = 7; // Prescaler width, eight taps
    localparam int MAX_CH = 4; // Channels the register map holds

endpackage : arpt_pkg

/* File: rtl/arpt_timer.sv */
// Auto-reload PWM timer with AHB-Lite register slave and four channels
// ==========================================================
`timescale 1ns/1ps

module arpt_timer
    import arpt_pkg::*;
#(
    parameter int NUM_CH = 4
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // External count clock pin
    input wire logic ext_count_clk,
    // PWM pins
    output logic [NUM_CH-1:0] pwm_channel_pin,
    output logic [NUM_CH-1:0] pwm_pin_oe_n,
    // Interrupt
    output logic irq
);

    // ==========================================================
    // Parameter check
    if (NUM_CH < 1 || NUM_CH > MAX_CH) begin : g_bad_ch
        $error("NUM_CH must lie between 1 and 4");
    end

    // ==========================================================
    // State
    logic ext_sync1_r; // First synchroniser stage
    logic ext_sync2_r; // Second synchroniser stage
    logic ext_prev_r; // Previous synced level, for edge detect
    logic ext_sel_r; // Prescaler input select
    logic [2:0] presc_sel_r; // Prescale tap
    logic cnt_en_r; // Count enable
    logic oie_r; // Overflow interrupt enable
    logic ovf_r; // Overflow flag
    logic [PRESC_W-1:0] presc_r; // Prescaler
    logic [7:0] cnt_r; // Counter
    logic [7:0] reload_r; // Auto-reload value
    logic [3:0] oe_r; // Output enables
    logic [3:0] pol_r; // Polarity selects
    logic int_stat_r; // Sticky overflow event
    logic int_en_r; // Event enable
    logic wr_en_r; // Write data phase pending
    logic [7:0] wr_idx_r; // Index of pending write
    logic [31:0] hrdata_r; // Read data for the data phase
    logic [7:0] duty_r [NUM_CH]; // Duty cycle registers
    logic [7:0] cmp_r [NUM_CH]; // Compare shadows
    logic [NUM_CH-1:0] pwm_pin_r; // Registered pin levels

    // ==========================================================
    // Bus decode
    wire bus_acc = hsel & hready & htrans[1]; // Address phase taken
    wire addr_ok = (haddr[31:10] == 22'h0); // Inside our window
    wire [7:0] a_idx = haddr[9:2]; // Register index
    wire rd_acc = bus_acc & ~hwrite & addr_ok; // Read taken
    wire rd_csr = rd_acc & (a_idx == IDX_CSR); // Read of status
    wire [7:0] wdat = hwdata[7:0]; // Narrow write data
    wire wr_csr = wr_en_r & (wr_idx_r == IDX_CSR);
    wire wr_car = wr_en_r & (wr_idx_r == IDX_CAR);
    wire wr_arr = wr_en_r & (wr_idx_r == IDX_ARR);
    wire wr_pwm_output_control = wr_en_r & (wr_idx_r == IDX_PWM_OUTPUT_CONTROL);
    wire wr_iclr = wr_en_r & (wr_idx_r == IDX_INT_CLR);
    wire wr_ien = wr_en_r & (wr_idx_r == IDX_INT_EN);
    wire wr_frl = wr_csr & wdat[CSR_FRELOAD];

    // Zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    // ==========================================================
    // Clock source, prescaler tap and counter tick
    wire ext_rise = ext_sync2_r & ~ext_prev_r; // Synced rising edge
    wire in_tick = ext_sel_r ? ext_rise : 1'b1;
    wire [7:0] tap_mask8 = (8'h01 << presc_sel_r) - 8'h01;
    wire [PRESC_W-1:0] tap_mask = tap_mask8[PRESC_W-1:0];
    wire presc_run = cnt_en_r & in_tick;
    wire cnt_tick = presc_run & ((presc_r & tap_mask) == tap_mask);
    wire sw_load = wr_car | wr_frl; // Software counter load
    wire ovf_evt = cnt_tick & (cnt_r == CNT_MAX) & ~sw_load;

    // Next values of prescaler, counter and flags
    wire [PRESC_W-1:0] presc_nxt =
        sw_load ? '0 : (presc_run ? presc_r + 1'b1 : presc_r);
    wire [7:0] cnt_inc = cnt_r + 8'h01;
    wire [7:0] cnt_nxt =
        wr_car ? wdat :
        wr_frl ? reload_r :
        ovf_evt ? reload_r :
        cnt_tick ? cnt_inc : cnt_r;
    // Set wins over the read that clears it
    wire ovf_nxt = ovf_evt | (ovf_r & ~rd_csr);
    wire int_stat_nxt =
        ovf_evt | (int_stat_r & ~(wr_iclr & wdat[INT_OVF_BIT]));

    // Request while an enabled flag stands
    assign irq = (ovf_r & oie_r) | (int_stat_r & int_en_r);

    // ==========================================================
    // Read mux
    logic [7:0] duty_rd [MAX_CH]; // Duty values, zero if not built
    for (genvar k = 0; k < MAX_CH; k++) begin : g_duty_rd
        if (k < NUM_CH) begin : g_on
            assign duty_rd[k] = duty_r[k];
        end else begin : g_off
            assign duty_rd[k] = 8'h00;
        end
    end

    // Force reload bit always reads zero
    wire [7:0] csr_rd = {ext_sel_r, presc_sel_r, cnt_en_r, 1'b0,
        oie_r, ovf_r};
    logic [7:0] rd_mux; // Selected register value
    always_comb begin
        unique case (a_idx)
            IDX_CSR: rd_mux = csr_rd;
            IDX_CAR: rd_mux = cnt_r;
            IDX_ARR: rd_mux = reload_r;
            IDX_PWM_OUTPUT_CONTROL: rd_mux = {oe_r, pol_r};
            IDX_DUTY0: rd_mux = duty_rd[0];
            IDX_DUTY1: rd_mux = duty_rd[1];
            IDX_DUTY2: rd_mux = duty_rd[2];
            IDX_DUTY3: rd_mux = duty_rd[3];
            IDX_INT_STAT: rd_mux = {7'h00, int_stat_r};
            IDX_INT_EN: rd_mux = {7'h00, int_en_r};
            default: rd_mux = 8'h00; // Unmapped and write-only
        endcase
    end

    // ==========================================================
    // Bus phase registers; read data captured at the address edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_en_r <= 1'b0;
            wr_idx_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
        end else begin
            wr_en_r <= bus_acc & hwrite & addr_ok;
            wr_idx_r <= a_idx;
            hrdata_r <= rd_acc ? {24'h00_0000, rd_mux} : 32'h0000_0000;
        end
    end

    // ==========================================================
    // External clock synchroniser, only stage two is read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_sync1_r <= 1'b0;
            ext_sync2_r <= 1'b0;
            ext_prev_r <= 1'b0;
        end else begin
            ext_sync1_r <= ext_count_clk;
            ext_sync2_r <= ext_sync1_r;
            ext_prev_r <= ext_sync2_r;
        end
    end

    // ==========================================================
    // Control, counter and flags; reset selects the CPU clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_sel_r <= CSR_RST[CSR_EXT_SEL];
            presc_sel_r <= CSR_RST[CSR_PS_HI:CSR_PS_LO];
            cnt_en_r <= CSR_RST[CSR_CNT_EN];
            oie_r <= CSR_RST[CSR_OIE];
            ovf_r <= CSR_RST[CSR_OVF];
            presc_r <= '0;
            cnt_r <= CNT_RST;
            reload_r <= ARR_RST;
            oe_r <= PWM_OUTPUT_CONTROL_RST[7:PWM_OUTPUT_CONTROL_OE_LO];
            pol_r <= PWM_OUTPUT_CONTROL_RST[PWM_OUTPUT_CONTROL_OE_LO-1:0];
            int_stat_r <= 1'b0;
            int_en_r <= 1'b0;
        end else begin
            if (wr_csr) begin
                ext_sel_r <= wdat[CSR_EXT_SEL];
                presc_sel_r <= wdat[CSR_PS_HI:CSR_PS_LO];
                cnt_en_r <= wdat[CSR_CNT_EN];
                oie_r <= wdat[CSR_OIE];
            end
            if (wr_arr) begin
                reload_r <= wdat;
            end
            if (wr_pwm_output_control) begin
                oe_r <= wdat[7:PWM_OUTPUT_CONTROL_OE_LO];
                pol_r <= wdat[PWM_OUTPUT_CONTROL_OE_LO-1:0];
            end
            if (wr_ien) begin
                int_en_r <= wdat[INT_OVF_BIT];
            end
            ovf_r <= ovf_nxt;
            int_stat_r <= int_stat_nxt;
            presc_r <= presc_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // ==========================================================
    // Per channel: duty register, compare shadow, output level
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        wire [7:0] duty_idx = IDX_DUTY0 - 8'(i); // Channels count down
        wire wr_duty = wr_en_r & (wr_idx_r == duty_idx);
        // Level for this cycle; one compare serves both edges
        wire lvl = (cnt_r <= cmp_r[i]) ^ pol_r[i];

        // Shadow only moves at overflow, so duty edits cannot glitch
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                duty_r[i] <= DUTY_RST;
                cmp_r[i] <= DUTY_RST;
                pwm_pin_r[i] <= 1'b0;
            end else begin
                if (wr_duty) begin
                    duty_r[i] <= wdat;
                end
                if (ovf_evt) begin
                    cmp_r[i] <= duty_r[i];
                end
                pwm_pin_r[i] <= oe_r[i] & lvl;
            end
        end

        assign pwm_channel_pin[i] = pwm_pin_r[i];
        assign pwm_pin_oe_n[i] = ~oe_r[i];

        // Pin follows compare result and polarity
        chk_pin_above_cmp: assert property (@(posedge hclk)
            disable iff (!hresetn)
            (oe_r[i] && cnt_r > cmp_r[i]) |=> pwm_pin_r[i] == $past(pol_r[i]))
            else $error("pin level wrong above compare");
        // Enable drive is combinational, the pin level lags by one cycle
        chk_pin_disabled: assert property (@(posedge hclk)
            disable iff (!hresetn)
            !oe_r[i] |-> pwm_pin_oe_n[i] ##1 !pwm_channel_pin[i])
            else $error("disabled channel drives pin");
        chk_pol_flip: assert property (@(posedge hclk)
            disable iff (!hresetn)
            ($changed(pol_r[i]) && $stable(cnt_r) && $stable(cmp_r[i])
            && oe_r[i] && $stable(oe_r[i]))
            |=> pwm_pin_r[i] != $past(pwm_pin_r[i]))
            else $error("polarity change did not invert pin");
        chk_shadow_hold: assert property (@(posedge hclk)
            disable iff (!hresetn)
            !ovf_evt |=> $stable(cmp_r[i]))
            else $error("compare shadow moved without overflow");
        chk_shadow_load: assert property (@(posedge hclk)
            disable iff (!hresetn)
            ovf_evt |=> cmp_r[i] == $past(duty_r[i]))
            else $error("compare shadow not loaded");
    end

    // ==========================================================
    // Checks on counter, prescaler and flags
    // Stuck at FF is legal when the reload value is FF as well
    chk_cpu_tick: assert property (@(posedge hclk)
        disable iff (!hresetn)
        (cnt_en_r && !ext_sel_r && presc_sel_r == 3'h0 && !wr_en_r
        && !(cnt_r == CNT_MAX && reload_r == CNT_MAX))
        |=> cnt_r != $past(cnt_r))
        else $error("CPU clock at div 1 did not count");
    chk_ext_idle: assert property (@(posedge hclk)
        disable iff (!hresetn)
        (ext_sel_r && ext_sync2_r == ext_prev_r && !wr_en_r)
        |=> $stable(cnt_r) && $stable(presc_r))
        else $error("counted without external edge");
    chk_div_max: assert property (@(posedge hclk)
        disable iff (!hresetn)
        (cnt_tick && presc_sel_r == 3'h7) |-> presc_r == 7'h7f)
        else $error("divide by 128 ticked early");
    chk_hold_off: assert property (@(posedge hclk)
        disable iff (!hresetn)
        (!cnt_en_r && !wr_en_r) |=> $stable(cnt_r) && $stable(presc_r))
        else $error("stopped timer moved");
    chk_force_load: assert property (@(posedge hclk)
        disable iff (!hresetn)
        wr_frl |=> cnt_r == $past(reload_r) && presc_r == '0)
        else $error("force reload failed");
    chk_fr_read_zero: assert property (@(posedge hclk)
        disable iff (!hresetn)
        rd_csr |=> hrdata[CSR_FRELOAD] == 1'b0)
        else $error("force reload bit read as one");
    chk_irq_gate: assert property (@(posedge hclk)
        disable iff (!hresetn)
        (!oie_r && !(int_stat_r && int_en_r)) |-> !irq)
        else $error("interrupt without enable");
    // Flag, sticky status and reload all land on the overflow edge;
    // a clear one cycle later is legal, so nothing is asked after it
    chk_ovf_reload: assert property (@(posedge hclk)
        disable iff (!hresetn)
        ovf_evt |=> ovf_r && int_stat_r && cnt_r == $past(reload_r))
        else $error("overflow did not reload and flag");
    chk_ovf_rdclr: assert property (@(posedge hclk)
        disable iff (!hresetn)
        (rd_csr && !ovf_evt) |=> !ovf_r)
        else $error("status read did not clear flag");
    chk_car_live: assert property (@(posedge hclk)
        disable iff (!hresetn)
        (rd_acc && a_idx == IDX_CAR) |=> hrdata[7:0] == $past(cnt_r))
        else $error("counter read not live");

    // Main scenarios
    cov_overflow: cover property (@(posedge hclk) disable iff (!hresetn)
        ovf_evt && reload_r != 8'h00);
    cov_ovf_clear: cover property (@(posedge hclk) disable iff (!hresetn)
        ovf_r && rd_csr);
    cov_ext_count: cover property (@(posedge hclk) disable iff (!hresetn)
        ext_sel_r && cnt_tick);
    cov_irq: cover property (@(posedge hclk) disable iff (!hresetn)
        irq && oie_r);
    // Polarity flipped while at least one channel drives its pin
    cov_pol_flip: cover property (@(posedge hclk) disable iff (!hresetn)
        $changed(pol_r) && oe_r != 4'h0);

endmodule : arpt_timer

/* File: verif/auto_reload_pwm_timer_bench.sv */
// Self-checking bench for the auto-reload PWM timer
`timescale 1ns/1ps

module auto_reload_pwm_timer_bench;
    import arpt_pkg::*;

    // ==========================================================
    // Stimulus and observed signals
    logic hclk, hresetn, hsel, hwrite, ext_count_clk;
    logic [31:0] haddr, hwdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire logic hready, hreadyout, hresp, irq;
    wire logic [31:0] hrdata;
    wire logic [3:0] pins, oe_n;
    int bad_count, checked, cycles;
    logic [31:0] rd;

    // One register access: inputs beside expected read-back
    typedef struct {
        logic [7:0] idx; // Register index
        logic [7:0] wd; // Value written
        logic [7:0] exp; // Value read back
    } arpt_row_t;
    arpt_row_t rows[14] = '{'{IDX_ARR, 8'h5a, 8'h5a},
        '{IDX_DUTY0, 8'ha1, 8'ha1}, '{IDX_DUTY1, 8'hb2, 8'hb2},
        '{IDX_DUTY2, 8'hc3, 8'hc3}, '{IDX_DUTY3, 8'hd4, 8'hd4},
        '{IDX_PWM_OUTPUT_CONTROL, 8'h3c, 8'h3c}, '{IDX_INT_EN, 8'h01, 8'h01},
        '{IDX_INT_EN, 8'h00, 8'h00}, '{IDX_INT_CLR, 8'hff, 8'h00},
        '{8'h7b, 8'hff, 8'h00}, '{8'h83, 8'hff, 8'h00},
        '{IDX_CSR, 8'h76, 8'h72}, '{IDX_CSR, 8'h01, 8'h00},
        '{IDX_CAR, 8'h33, 8'h33}};
    logic [7:0] rst_idx[11] = '{IDX_DUTY3, IDX_DUTY2, IDX_DUTY1, IDX_DUTY0,
        IDX_PWM_OUTPUT_CONTROL, IDX_CSR, IDX_CAR, IDX_ARR, IDX_INT_STAT, IDX_INT_CLR,
        IDX_INT_EN};

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;

    // ==========================================================
    // Design under test
    arpt_timer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .ext_count_clk(ext_count_clk),
        .pwm_channel_pin(pins), .pwm_pin_oe_n(oe_n), .irq(irq));

    // Free-running 50 MHz clock
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // Cycle ceiling well above the expected run
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            $display("ERROR timeout expected done seen hang");
            end_of_test();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // AHB-Lite single word transfer; read data taken at data-phase edge
    task automatic bus(input logic [7:0] idx, input logic wr,
                       input logic [7:0] wd, output logic [31:0] rdv);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rdv = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [31:0] dummy;
        bus(idx, 1'b1, wd, dummy);
    endtask : wr

    task automatic rd_chk(input string what, input logic [7:0] idx,
                          input logic [7:0] exp);
        bus(idx, 1'b0, 8'h00, rd);
        chk(what, {24'h0, exp}, rd);
    endtask : rd_chk

    // Pins settle one cycle after the register lands
    task automatic pin_chk(input logic [3:0] ep, input logic [3:0] eo);
        repeat (2) @(posedge hclk);
        #1;
        chk("pins", {28'h0, ep}, {28'h0, pins});
        chk("oe_n", {28'h0, eo}, {28'h0, oe_n});
    endtask : pin_chk

    // Apply reset for six cycles and check every reset value
    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (6) @(posedge hclk);
        // Released at this edge; outputs keep reset values until the next
        hresetn <= 1'b1;
        #1;
        chk("irq_rst", 32'h0, {31'h0, irq});
        chk("pins_rst", 32'h0, {28'h0, pins});
        chk("oe_rst", 32'hf, {28'h0, oe_n});
        chk("hresp_rst", 32'h0, {31'h0, hresp});
        chk("hready_rst", 32'h1, {31'h0, hreadyout});
        foreach (rst_idx[i]) rd_chk("reset_val", rst_idx[i], 8'h00);
    endtask : do_reset

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test

    // ==========================================================
    // Main sequence
    initial begin
        int exp;
        hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00;
        hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0; ext_count_clk = 1'b0;
        do_reset();
        // Table of plain register accesses
        foreach (rows[i]) begin
            wr(rows[i].idx, rows[i].wd);
            rd_chk("row", rows[i].idx, rows[i].exp);
        end
        // Every prescale tap, counting from a written start value
        for (int p = 0; p < 8; p++) begin
            wr(IDX_CSR, 8'h08 | 8'(p << 4));
            wr(IDX_CAR, 8'h20);
            repeat (8 << p) @(posedge hclk);
            bus(IDX_CAR, 1'b0, 8'h00, rd);
            exp = 32'h20 + ((8 << p) + 1) / (1 << p);
            chk("presc", 32'(exp), rd);
        end
        // Count disabled freezes the counter
        wr(IDX_CSR, 8'h00);
        bus(IDX_CAR, 1'b0, 8'h00, rd);
        repeat (40) @(posedge hclk);
        rd_chk("frozen", IDX_CAR, rd[7:0]);
        // External clock, five edges, divide by one
        wr(IDX_CSR, 8'h88);
        wr(IDX_CAR, 8'h00);
        repeat (5) begin
            repeat (4) @(posedge hclk);
            ext_count_clk <= 1'b1;
            repeat (4) @(posedge hclk);
            ext_count_clk <= 1'b0;
        end
        repeat (6) @(posedge hclk);
        rd_chk("ext_count", IDX_CAR, 8'h05);
        // Overflow every four cycles with the interrupt enabled
        wr(IDX_ARR, 8'hfc);
        wr(IDX_CSR, 8'h0e);
        repeat (10) @(posedge hclk);
        chk("irq_oie", 32'h1, {31'h0, irq});
        rd_chk("csr_ovf", IDX_CSR, 8'h0b);
        wr(IDX_CSR, 8'h0c);
        repeat (10) @(posedge hclk);
        chk("irq_masked", 32'h0, {31'h0, irq});
        rd_chk("int_stat", IDX_INT_STAT, 8'h01);
        wr(IDX_INT_EN, 8'h01);
        @(posedge hclk);
        chk("irq_en", 32'h1, {31'h0, irq});
        wr(IDX_INT_EN, 8'h00);
        wr(IDX_CSR, 8'h00);
        bus(IDX_CSR, 1'b0, 8'h00, rd);
        rd_chk("ovf_clr", IDX_CSR, 8'h00);
        wr(IDX_INT_CLR, 8'h01);
        rd_chk("int_clr", IDX_INT_STAT, 8'h00);
        // Load compare shadows through a real overflow
        wr(IDX_DUTY0, 8'h80);
        wr(IDX_DUTY1, 8'h20);
        wr(IDX_DUTY2, 8'h40);
        wr(IDX_DUTY3, 8'h3f);
        wr(IDX_ARR, 8'hfe);
        // The enabling write also force-reloads ARR (FE), so the second tick overflows
        wr(IDX_CAR, 8'hff);
        wr(IDX_CSR, 8'h0c);
        wr(IDX_CSR, 8'h00);
        wr(IDX_CAR, 8'h40);
        wr(IDX_PWM_OUTPUT_CONTROL, 8'hf0);
        pin_chk(4'b0101, 4'b0000);
        wr(IDX_PWM_OUTPUT_CONTROL, 8'hff);
        pin_chk(4'b1010, 4'b0000);
        wr(IDX_PWM_OUTPUT_CONTROL, 8'haf);
        pin_chk(4'b1010, 4'b0101);
        // Duty change stays hidden until the next overflow
        wr(IDX_PWM_OUTPUT_CONTROL, 8'hf0);
        wr(IDX_DUTY1, 8'hff);
        pin_chk(4'b0101, 4'b0000);
        wr(IDX_CAR, 8'hff);
        wr(IDX_CSR, 8'h0c);
        wr(IDX_CSR, 8'h00);
        wr(IDX_CAR, 8'h40);
        pin_chk(4'b0111, 4'b0000);
        // Second reset in mid-run
        wr(IDX_CSR, 8'h0c);
        do_reset();
        end_of_test();
    end

endmodule : auto_reload_pwm_timer_bench
